// *** design/stm_regs.svh ***
`ifndef STM_REGS_SVH
`define STM_REGS_SVH
// Register indices; byte address is four times the index
`define STM_IDX_CTRL   30'h01FF8050
`define STM_IDX_STEP   30'h01FF8052
`define STM_IDX_DELAY  30'h01FF8054
`define STM_IDX_PAT    30'h01FF8056
`define STM_IDX_CUR1   30'h01FF804C
`define STM_IDX_CUR2   30'h01FF804E
`define STM_IDX_DIV    30'h01FF8850
// Control bit positions
`define STM_B_IRQCLR   0
`define STM_B_EN       1
`define STM_B_DIR      2
`define STM_B_HALF     3
`define STM_B_SYNC     4
`define STM_B_PWR      5
`define STM_B_SMISEL   6
`define STM_B_CDEF     8
`define STM_B_C1       10
`define STM_B_C2       12
`define STM_B_C3       14
// Reset values
`define STM_CTRL_RST   16'hFF00
`define STM_CUR_RST    2'h3
// Timing
`define STM_DIV_BASE   8
`define STM_TMR_W      14
`define STM_THR_W      12
`define STM_DIV_W      5
`endif

// *** design/stm_pkg.sv ***
package stm_pkg;
    typedef logic [3:0] stm_nib_t;
    typedef logic [1:0] stm_cur_t;
    typedef enum logic [3:0]
    {
        ST_IDLE  = 4'b0001,
        ST_WAIT  = 4'b0010,
        ST_DELAY = 4'b0100,
        ST_STEP  = 4'b1000
    } stm_state_t;
endpackage

// *** design/stm_tick_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface stm_tick_if;
    logic [4:0] div_n;
    logic       run;
    logic       tick;
    modport ctl (output div_n, output run, input tick);
    modport gen (input div_n, input run, output tick);
endinterface
`default_nettype wire

// *** design/stm_stepping_clock_div.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "stm_regs.svh"
module stm_stepping_clock_div
(
    input  wire logic pclk,
    input  wire logic presetn,
    stm_tick_if.gen   tk
);
    import stm_pkg::*;
    logic [7:0] cnt_q;
    logic [7:0] lim;

    // One enable per 8*(n+1) clocks
    assign lim = {tk.div_n, 3'h7};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q   <= 8'h00;
            tk.tick <= 1'b0;
        end
        else if (!tk.run)
        begin
            cnt_q   <= 8'h00;
            tk.tick <= 1'b0;
        end
        else
        begin
            tk.tick <= (cnt_q == lim);
            cnt_q   <= (cnt_q == lim) ? 8'h00 : cnt_q + 8'h01;
        end
    end

    a_tick_gap: assert property (@(posedge pclk) disable iff (!presetn)
        tk.tick |=> !tk.tick [*7]) else $error("step clock enable too close");
endmodule // stm_stepping_clock_div
`default_nettype wire

// *** design/stm_motor_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "stm_regs.svh"
// Behaviour
// - Stepping clock is clock over 8*(n+1)
// - Divider spans fast to slow stepping rates
// - Step timer spans 14 bits of ticks
// - Pre-step delay timer runs before first step
// - Control bit 2 picks rotation sense
// - Control bit 3 picks full or half step
// - Control bit 4 waits delay load for sync
// - Bit 1 enables stepping, bit 0 clears interrupt
// - Control bit 5 drives motor power output
// - Full step uses low pattern nibble only
// - Half step pairs nibbles, outputs low nibble
// - Two-bit winding current code output
// - Two thresholds split step into three periods
// - Period codes from bits 11:10, 13:12, 15:14
// - Thresholds and codes take effect next step
// - Current forced to 11 at reset, GENERAL_PURPOSE_OUTPUT mode
// - Disabled stepping drives default code bits 9:8
// - Bit 6 routes current code to shared pins
// - Step interval is n+1 stepping clocks
// - First threshold switches to second code
// - Second threshold switches to third code
// - Expiry advances pattern, reloads, raises interrupt
module stm_motor_ctrl
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [31:0]  paddr,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [31:0]  pwdata,
    input  wire logic [3:0]   pstrb,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic         scan_start_sync_pulse,
    input  wire logic         gp_out_mode,
    input  wire stm_pkg::stm_nib_t general_purpose_output,
    output stm_pkg::stm_nib_t shared_motor_pins,
    output stm_pkg::stm_nib_t phase_outputs,
    output stm_pkg::stm_cur_t winding_current_code,
    output logic              motor_power_output,
    output logic              step_interrupt
);
    import stm_pkg::*;

    logic [15:0]           ctrl_q;
    logic                  irq_q;
    logic [`STM_TMR_W-1:0] step_q;
    logic [`STM_TMR_W-1:0] delay_q;
    logic [7:0]            pat_q;
    logic [`STM_DIV_W-1:0] div_q;
    logic [`STM_THR_W-1:0] cur1_q;
    logic [`STM_THR_W-1:0] cur2_q;
    logic [`STM_THR_W-1:0] thr1_a_q;
    logic [`STM_THR_W-1:0] thr2_a_q;
    logic [5:0]            codes_a_q;
    logic [`STM_TMR_W-1:0] sval_a_q;
    logic [`STM_TMR_W-1:0] cnt_q;
    stm_state_t            state_q;
    stm_cur_t              cur_q;
    stm_nib_t              pins_q;
    logic [31:0]           rdata_q;
    logic                  err_q;
    logic                  sync1_q;
    logic                  sync2_q;
    logic                  sync3_q;
    logic                  sync_edge;
    logic                  en;
    logic                  acc;
    logic                  wr;
    logic [15:0]           wmask;
    logic [15:0]           wval;
    logic                  hit_ctrl;
    logic                  hit_step;
    logic                  hit_delay;
    logic                  hit_pat;
    logic                  hit_cur1;
    logic                  hit_cur2;
    logic                  hit_div;
    logic                  mapped;
    logic                  irq_clr;
    logic                  load_delay;
    logic                  step_pulse;
    logic                  thr1_ok;
    logic                  thr2_ok;
    logic [15:0]           rsel;

    stm_tick_if tk ();

    stm_stepping_clock_div u_div
    (
        .pclk    (pclk),
        .presetn (presetn),
        .tk      (tk.gen)
    );

    assign tk.div_n = div_q;
    assign tk.run   = en;

    // APB decode
    assign acc       = psel & penable;
    assign wr        = acc & pwrite & ~err_q;
    assign wmask     = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    assign wval      = pwdata[15:0];
    assign hit_ctrl  = (paddr[31:2] == `STM_IDX_CTRL);
    assign hit_step  = (paddr[31:2] == `STM_IDX_STEP);
    assign hit_delay = (paddr[31:2] == `STM_IDX_DELAY);
    assign hit_pat   = (paddr[31:2] == `STM_IDX_PAT);
    assign hit_cur1  = (paddr[31:2] == `STM_IDX_CUR1);
    assign hit_cur2  = (paddr[31:2] == `STM_IDX_CUR2);
    assign hit_div   = (paddr[31:2] == `STM_IDX_DIV);
    assign mapped    = hit_ctrl | hit_step | hit_delay | hit_pat | hit_cur1 | hit_cur2 | hit_div;
    assign pready    = 1'b1;
    assign pslverr   = acc & err_q;
    assign prdata    = rdata_q;

    always_comb
    begin
        rsel = 16'h0000;
        if (hit_ctrl)
            rsel = {ctrl_q[15:8], 1'b0, ctrl_q[6:1], irq_q};
        else if (hit_step)
            rsel = {2'h0, step_q};
        else if (hit_delay)
            rsel = {2'h0, delay_q};
        else if (hit_pat)
            rsel = {8'h00, pat_q};
        else if (hit_cur1)
            rsel = {4'h0, cur1_q};
        else if (hit_cur2)
            rsel = {4'h0, cur2_q};
        else if (hit_div)
            rsel = {11'h000, div_q};
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end
        else if (psel && !penable)
        begin
            rdata_q <= {16'h0000, rsel};
            err_q   <= ~mapped;
        end
    end

    // Control register; bit 0 is a write-one strobe
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= `STM_CTRL_RST;
        else if (wr && hit_ctrl)
            ctrl_q <= ((ctrl_q & ~wmask) | (wval & wmask)) & 16'hFF7E;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            step_q  <= 14'h0000;
            delay_q <= 14'h0000;
            cur1_q  <= 12'h000;
            cur2_q  <= 12'h000;
            div_q   <= 5'h00;
        end
        else if (wr)
        begin
            if (hit_step)
                step_q <= (step_q & wmask[13:0]) ^ ((step_q ^ wval[13:0]) & wmask[13:0])
                          | (step_q & ~wmask[13:0]);
            if (hit_delay)
                delay_q <= (delay_q & ~wmask[13:0]) | (wval[13:0] & wmask[13:0]);
            if (hit_cur1)
                cur1_q <= (cur1_q & ~wmask[11:0]) | (wval[11:0] & wmask[11:0]);
            if (hit_cur2)
                cur2_q <= (cur2_q & ~wmask[11:0]) | (wval[11:0] & wmask[11:0]);
            if (hit_div && pstrb[0])
                div_q <= wval[4:0];
        end
    end

    assign en      = ctrl_q[`STM_B_EN];
    assign irq_clr = wr & hit_ctrl & pstrb[0] & wval[`STM_B_IRQCLR];

    // Scan start pulse synchroniser and edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end
        else
        begin
            sync1_q <= scan_start_sync_pulse;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end
    assign sync_edge = sync2_q & ~sync3_q;

    assign load_delay = en && ((state_q == ST_IDLE && !ctrl_q[`STM_B_SYNC])
                        || (state_q == ST_WAIT && sync_edge));
    assign step_pulse = en && tk.tick && cnt_q == 14'h0000
                        && (state_q == ST_DELAY || state_q == ST_STEP);

    // Step and delay timer sequencing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ST_IDLE;
            cnt_q   <= 14'h0000;
        end
        else if (!en)
        begin
            state_q <= ST_IDLE;
            cnt_q   <= 14'h0000;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    if (load_delay)
                    begin
                        cnt_q   <= delay_q;
                        state_q <= ST_DELAY;
                    end
                    else
                        state_q <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (load_delay)
                    begin
                        cnt_q   <= delay_q;
                        state_q <= ST_DELAY;
                    end
                end
                ST_DELAY, ST_STEP:
                begin
                    if (step_pulse)
                    begin
                        cnt_q   <= step_q;
                        state_q <= ST_STEP;
                    end
                    else if (tk.tick)
                        cnt_q <= cnt_q - 14'h0001;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // Double-buffered thresholds and codes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            thr1_a_q  <= 12'h000;
            thr2_a_q  <= 12'h000;
            codes_a_q <= 6'h3F;
            sval_a_q  <= 14'h0000;
        end
        else if (load_delay || step_pulse)
        begin
            thr1_a_q  <= cur1_q;
            thr2_a_q  <= cur2_q;
            codes_a_q <= ctrl_q[15:10];
            sval_a_q  <= step_pulse ? step_q : delay_q;
        end
    end

    assign thr1_ok = (thr1_a_q != 12'h000) && ({2'h0, thr1_a_q} < sval_a_q);
    assign thr2_ok = (thr2_a_q != 12'h000) && (thr2_a_q < thr1_a_q);

    // Winding current code
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cur_q <= `STM_CUR_RST;
        else if (gp_out_mode)
            cur_q <= `STM_CUR_RST;
        else if (!en)
            cur_q <= ctrl_q[`STM_B_CDEF +: 2];
        else if (state_q == ST_STEP && thr2_ok && {2'h0, thr2_a_q} >= cnt_q)
            cur_q <= codes_a_q[5:4];
        else if (state_q == ST_STEP && thr1_ok && {2'h0, thr1_a_q} >= cnt_q)
            cur_q <= codes_a_q[3:2];
        else
            cur_q <= codes_a_q[1:0];
    end

    // Phase pattern register and advance
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pat_q <= 8'h00;
        else if (wr && hit_pat && gp_out_mode && pstrb[0])
            pat_q <= wval[7:0];
        else if (step_pulse && !ctrl_q[`STM_B_HALF])
        begin
            if (!ctrl_q[`STM_B_DIR])
                pat_q[3:0] <= {pat_q[2:0], pat_q[3]};
            else
                pat_q[3:0] <= {pat_q[0], pat_q[3:1]};
        end
        else if (step_pulse)
        begin
            if (!ctrl_q[`STM_B_DIR])
                pat_q <= {pat_q[2:0], pat_q[3], pat_q[7:4]};
            else
                pat_q <= {pat_q[3:0], pat_q[4], pat_q[7:5]};
        end
    end

    // Step interrupt, clear wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_q <= 1'b0;
        else if (irq_clr)
            irq_q <= 1'b0;
        else if (step_pulse)
            irq_q <= 1'b1;
    end

    // Shared pin routing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pins_q <= 4'h0;
        else
        begin
            pins_q[1:0] <= gp_out_mode ? general_purpose_output[1:0] : pat_q[1:0];
            if (ctrl_q[`STM_B_SMISEL])
                pins_q[3:2] <= cur_q;
            else
                pins_q[3:2] <= gp_out_mode ? general_purpose_output[3:2] : pat_q[3:2];
        end
    end

    assign shared_motor_pins    = pins_q;
    assign phase_outputs        = pat_q[3:0];
    assign winding_current_code = cur_q;
    assign motor_power_output   = ctrl_q[`STM_B_PWR];
    assign step_interrupt       = irq_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_step_fwd_full;
        step_pulse && !ctrl_q[`STM_B_HALF] && !ctrl_q[`STM_B_DIR];
    endsequence
    sequence s_step_half;
        step_pulse && ctrl_q[`STM_B_HALF] && !(wr && hit_pat);
    endsequence
    sequence s_ctrl_write;
        wr && hit_ctrl && pstrb[0];
    endsequence

    a_irq_set: assert property (step_pulse && !irq_clr |=> step_interrupt)
        else $error("step did not raise interrupt");
    a_irq_clear: assert property (irq_clr |=> !step_interrupt)
        else $error("clear did not drop interrupt");
    a_step_reload: assert property (step_pulse |=> cnt_q == $past(step_q))
        else $error("step timer not reloaded");
    a_dis_clear: assert property (!en |=> cnt_q == 14'h0000 && !step_pulse)
        else $error("disable did not clear timers");
    a_full_fwd: assert property (s_step_fwd_full ##0 !(wr && hit_pat)
        |=> phase_outputs == {$past(pat_q[2:0]), $past(pat_q[3])})
        else $error("full step advance wrong");
    a_half_adv: assert property (s_step_half
        |=> phase_outputs == ($past(ctrl_q[`STM_B_DIR])
        ? {$past(pat_q[4]), $past(pat_q[7:5])} : $past(pat_q[7:4])))
        else $error("half step advance wrong");
    a_pwr_out: assert property (s_ctrl_write |=> motor_power_output == $past(wval[5]))
        else $error("power output not following write");
    a_cur_forced: assert property (gp_out_mode |=> winding_current_code == 2'h3)
        else $error("current not forced in output mode");
    a_cur_default: assert property (!gp_out_mode && !en && $stable(ctrl_q)
        |=> winding_current_code == $past(ctrl_q[9:8]))
        else $error("default current code not driven");
    a_sync_wait: assert property (state_q == ST_WAIT && en && !sync_edge
        |=> state_q == ST_WAIT)
        else $error("delay loaded without sync");
    a_cur_pins: assert property (ctrl_q[`STM_B_SMISEL]
        |=> shared_motor_pins[3:2] == $past(cur_q))
        else $error("current code not on shared pins");
endmodule // stm_motor_ctrl
`default_nettype wire

// *** dv/stm_drv_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module stm_drv_model
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire stm_pkg::stm_nib_t phase,
    input  wire stm_pkg::stm_cur_t cur,
    input  wire logic              sync_req,
    output logic                   sync_pulse,
    output logic [15:0]            steps,
    output logic [15:0]            gap,
    output logic [7:0]             hist
);
    import stm_pkg::*;
    stm_nib_t    ph_q;
    stm_cur_t    cur_q;
    logic [15:0] cnt_q;
    // Scan start pulse from the scanner side
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sync_pulse <= 1'b0;
        else
            sync_pulse <= sync_req;
    end
    // Winding changes and their spacing in clocks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ph_q <= 4'h0;
            cnt_q <= 16'h0000;
            steps <= 16'h0000;
            gap <= 16'h0000;
        end
        else if (phase !== ph_q)
        begin
            ph_q <= phase;
            steps <= steps + 16'h0001;
            gap <= cnt_q;
            cnt_q <= 16'h0001;
        end
        else
            cnt_q <= cnt_q + 16'h0001;
    end
    // History of current codes seen on the driver
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cur_q <= 2'h3;
            hist <= 8'h00;
        end
        else if (cur !== cur_q)
        begin
            cur_q <= cur;
            hist <= {hist[5:0], cur};
        end
    end
endmodule // stm_drv_model
`default_nettype wire

// *** dv/stm_motor_ctrl_test.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "stm_regs.svh"
module stm_motor_ctrl_test;
    import stm_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sync_req = 1'b0;
    logic        sync_pulse;
    logic        gp_out_mode = 1'b0;
    stm_nib_t    gp_data = 4'hA;
    stm_nib_t    pins;
    stm_nib_t    phase;
    stm_cur_t    cur;
    logic        pwr;
    logic        irq;
    logic [15:0] steps;
    logic [15:0] gap;
    logic [7:0]  hist;
    logic [15:0] s0;
    logic [31:0] rd;
    logic        err;
    int          error_cnt = 0;
    int          n_checks = 0;
    int          cyc = 0;

    always #2 pclk = ~pclk;

    stm_motor_ctrl stm_motor_ctrl_i
    (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scan_start_sync_pulse(sync_pulse), .gp_out_mode(gp_out_mode),
        .general_purpose_output(gp_data), .shared_motor_pins(pins),
        .phase_outputs(phase), .winding_current_code(cur),
        .motor_power_output(pwr), .step_interrupt(irq)
    );

    stm_drv_model stm_drv_model_i
    (
        .pclk(pclk), .presetn(presetn), .phase(phase), .cur(cur),
        .sync_req(sync_req), .sync_pulse(sync_pulse), .steps(steps),
        .gap(gap), .hist(hist)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [29:0] idx, input logic [15:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= {idx, 2'b00};
        pwrite <= wr;
        pwdata <= {16'h0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge pclk);
            n++;
        end
        chk(pready, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic step_wait;
        int n;
        n = 0;
        s0 = steps;
        while (steps === s0 && n < 4000)
        begin
            @(posedge pclk);
            n++;
        end
        chk(steps !== s0, 1'b1);
        repeat (4) @(posedge pclk);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            stop_test;
        end
    end

    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk(cur, 2'b11);
        apb(1'b0, `STM_IDX_CTRL, 16'h0);
        chk(rd, 32'h0000FF00);
        apb(1'b0, `STM_IDX_STEP, 16'h0);
        chk(rd, 32'h0);
        apb(1'b0, 30'h01FF8060, 16'h0);
        chk(err, 1'b1);
        chk(pwr, 1'b0);
        $display("test reset done");
        gp_out_mode <= 1'b1;
        apb(1'b1, `STM_IDX_PAT, 16'h0023);
        apb(1'b0, `STM_IDX_PAT, 16'h0);
        chk(rd, 32'h23);
        chk(cur, 2'b11);
        chk(pins[3:2], 2'b10);
        gp_out_mode <= 1'b0;
        apb(1'b1, `STM_IDX_CTRL, 16'h0160);
        repeat (3) @(posedge pclk);
        chk(cur, 2'b01);
        chk(pins[3:2], 2'b01);
        chk(pwr, 1'b1);
        $display("test pins done");
        apb(1'b1, `STM_IDX_DIV, 16'h1);
        apb(1'b1, `STM_IDX_DELAY, 16'h0);
        apb(1'b1, `STM_IDX_STEP, 16'h2);
        apb(1'b1, `STM_IDX_CTRL, 16'h000A);
        step_wait;
        chk(phase, 4'h2);
        chk(irq, 1'b1);
        apb(1'b1, `STM_IDX_CTRL, 16'h000B);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        step_wait;
        chk(phase, 4'h6);
        chk(gap, 32'd48);
        apb(1'b1, `STM_IDX_CTRL, 16'h000F);
        step_wait;
        chk(phase, 4'h2);
        apb(1'b0, `STM_IDX_PAT, 16'h0);
        chk(rd, 32'h62);
        $display("test half step done");
        apb(1'b1, `STM_IDX_CTRL, 16'h0000);
        s0 = steps;
        repeat (200) @(posedge pclk);
        chk(steps, s0);
        chk(irq, 1'b1);
        apb(1'b1, `STM_IDX_CTRL, 16'h0001);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        $display("test disable done");
        gp_out_mode <= 1'b1;
        apb(1'b1, `STM_IDX_PAT, 16'h0051);
        gp_out_mode <= 1'b0;
        apb(1'b1, `STM_IDX_DIV, 16'h0);
        apb(1'b1, `STM_IDX_STEP, 16'd20);
        apb(1'b1, `STM_IDX_CUR1, 16'd10);
        apb(1'b1, `STM_IDX_CUR2, 16'd5);
        apb(1'b1, `STM_IDX_CTRL, 16'h2416);
        s0 = steps;
        repeat (100) @(posedge pclk);
        chk(steps, s0);
        sync_req <= 1'b1;
        repeat (4) @(posedge pclk);
        sync_req <= 1'b0;
        step_wait;
        chk(phase, 4'h8);
        apb(1'b1, `STM_IDX_CTRL, 16'h2C16);
        step_wait;
        chk(phase, 4'h4);
        chk(hist[5:0], 6'b100011);
        apb(1'b1, `STM_IDX_CTRL, 16'h2C12);
        step_wait;
        chk(phase, 4'h8);
        $display("test current done");
        stop_test;
    end
endmodule // stm_motor_ctrl_test
`default_nettype wire
